// [include/dcg_defines.vh]
`ifndef DCG_DEFINES_VH
`define DCG_DEFINES_VH

// Debug command byte values
`define DCG_CMD_RD_REV 8'h00
`define DCG_CMD_WR_CNT 8'h01
`define DCG_CMD_RD_STAT 8'h02
`define DCG_CMD_RD_CNT 8'h03
`define DCG_CMD_WR_CTL 8'h04
`define DCG_CMD_RD_CTL 8'h05
`define DCG_CMD_WR_PC 8'h06
`define DCG_CMD_RD_PC 8'h07
`define DCG_CMD_WR_REG 8'h08

// Operand bytes that follow each writing command
`define DCG_OPN_WR_CNT 2'd2
`define DCG_OPN_WR_CTL 2'd1
`define DCG_OPN_WR_PC 2'd2
`define DCG_OPN_WR_REG 2'd3

// Debug control register layout and reset value
`define DCG_CTL_MODE_BIT 7
`define DCG_CTL_RESET 8'h00
`define DCG_CNT_RESET 16'h0000

// Peripheral control page: addresses F00H..FFFH
`define DCG_PERIPH_PAGE 4'hf
`define DCG_FLASH_CTL_ADDR 12'hff8
`define DCG_MASS_ERASE_VAL 8'h95

// Autobaud: the first character holds eight low bit times
`define DCG_AUTOBAUD_SHIFT 3
`define DCG_BAUD_CNT_W 12

`endif

// [rtl/dcg_serial_rx.v]
`timescale 1ns/1ps
`default_nettype none
`include "dcg_defines.vh"

module dcg_serial_rx #(
  parameter CNT_W = `DCG_BAUD_CNT_W
) (
  input wire clk_i,
  input wire reset_i,
  input wire line_i,
  output reg byte_valid_r,
  output reg [7:0] byte_data_r,
  output reg frame_err_r,
  output reg baud_locked_r
);
  localparam S_AB_WAIT = 3'd0;
  localparam S_AB_MEAS = 3'd1;
  localparam S_IDLE = 3'd2;
  localparam S_START = 3'd3;
  localparam S_DATA = 3'd4;
  localparam S_STOP = 3'd5;

  reg [2:0] state_r;
  reg [CNT_W-1:0] tick_r;
  reg [CNT_W-1:0] bit_len_r;
  reg [2:0] bit_idx_r;
  reg line_q_r;

  // Half a bit time, rounded down; zero when a bit lasts one cycle
  wire [CNT_W-1:0] half_len = {1'b0, bit_len_r[CNT_W-1:1]};
  wire tick_done = (tick_r == {CNT_W{1'b0}});
  wire fall = line_q_r & ~line_i;

  // Autobaud then LSB-first framing with start and stop bits
  always @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= S_AB_WAIT;
      tick_r <= {CNT_W{1'b0}};
      bit_len_r <= {{(CNT_W-1){1'b0}}, 1'b1};
      bit_idx_r <= 3'd0;
      line_q_r <= 1'b1;
      byte_valid_r <= 1'b0;
      byte_data_r <= 8'h00;
      frame_err_r <= 1'b0;
      baud_locked_r <= 1'b0;
    end else begin
      line_q_r <= line_i;
      byte_valid_r <= 1'b0;
      frame_err_r <= 1'b0;
      case (state_r)
        S_AB_WAIT: begin
          if (fall) begin
            tick_r <= {{(CNT_W-1){1'b0}}, 1'b1};
            state_r <= S_AB_MEAS;
          end
        end
        S_AB_MEAS: begin
          // The 80H character is consumed, not passed on
          if (line_i) begin
            bit_len_r <= (tick_r >> `DCG_AUTOBAUD_SHIFT) == {CNT_W{1'b0}} ?
                         {{(CNT_W-1){1'b0}}, 1'b1} :
                         (tick_r >> `DCG_AUTOBAUD_SHIFT);
            baud_locked_r <= 1'b1;
            state_r <= S_IDLE;
          end else if (tick_r != {CNT_W{1'b1}}) begin
            tick_r <= tick_r + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        S_IDLE: begin
          if (fall) begin
            tick_r <= half_len;
            state_r <= S_START;
          end
        end
        S_START: begin
          if (tick_done) begin
            // Glitch shorter than half a bit is not a start
            if (line_i) begin
              state_r <= S_IDLE;
            end else begin
              tick_r <= bit_len_r - {{(CNT_W-1){1'b0}}, 1'b1};
              bit_idx_r <= 3'd0;
              state_r <= S_DATA;
            end
          end else begin
            tick_r <= tick_r - {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        S_DATA: begin
          if (tick_done) begin
            byte_data_r <= {line_i, byte_data_r[7:1]};
            tick_r <= bit_len_r - {{(CNT_W-1){1'b0}}, 1'b1};
            bit_idx_r <= bit_idx_r + 3'd1;
            if (bit_idx_r == 3'd7) begin
              state_r <= S_STOP;
            end
          end else begin
            tick_r <= tick_r - {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        S_STOP: begin
          if (tick_done) begin
            byte_valid_r <= line_i;
            frame_err_r <= ~line_i;
            state_r <= S_IDLE;
          end else begin
            tick_r <= tick_r - {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_r <= S_AB_WAIT;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [rtl/dcg_cmd_decode.v]
`timescale 1ns/1ps
`default_nettype none
`include "dcg_defines.vh"

module dcg_cmd_decode (
  input wire [7:0] cmd_i,
  input wire debug_mode_i,
  input wire read_protect_i,
  output wire known_o,
  output wire allowed_o,
  output wire [1:0] opnd_cnt_o
);
  // Permission table by command, mode and protection
  function allow_fn;
    input [7:0] c;
    input dbg;
    input rp;
    begin
      case (c)
        `DCG_CMD_RD_REV, `DCG_CMD_RD_STAT: allow_fn = 1'b1;
        `DCG_CMD_WR_CTL, `DCG_CMD_RD_CTL: allow_fn = 1'b1;
        `DCG_CMD_WR_CNT, `DCG_CMD_RD_CNT: allow_fn = dbg;
        `DCG_CMD_WR_PC, `DCG_CMD_RD_PC: allow_fn = dbg & ~rp;
        `DCG_CMD_WR_REG: allow_fn = dbg;
        default: allow_fn = 1'b0;
      endcase
    end
  endfunction

  function [1:0] opnd_fn;
    input [7:0] c;
    begin
      case (c)
        `DCG_CMD_WR_CNT: opnd_fn = `DCG_OPN_WR_CNT;
        `DCG_CMD_WR_CTL: opnd_fn = `DCG_OPN_WR_CTL;
        `DCG_CMD_WR_PC: opnd_fn = `DCG_OPN_WR_PC;
        `DCG_CMD_WR_REG: opnd_fn = `DCG_OPN_WR_REG;
        default: opnd_fn = 2'd0;
      endcase
    end
  endfunction

  assign known_o = (cmd_i <= `DCG_CMD_WR_REG);
  assign allowed_o = allow_fn(cmd_i, debug_mode_i, read_protect_i);
  assign opnd_cnt_o = opnd_fn(cmd_i);
endmodule
`default_nettype wire

// [rtl/dcg_debug_command_gate.v]
`timescale 1ns/1ps
`default_nettype none
`include "dcg_defines.vh"

module dcg_debug_command_gate #(
  parameter CNT_W = `DCG_BAUD_CNT_W,
  parameter [11:0] FLASH_CTL_ADDR = `DCG_FLASH_CTL_ADDR,
  parameter [7:0] MASS_ERASE_VAL = `DCG_MASS_ERASE_VAL
) (
  input wire clk_i,
  input wire reset_i,
  input wire debug_serial_pin_i,
  output reg debug_serial_pin_o,
  output reg debug_serial_pin_oe_o,
  input wire read_protect_option_i,
  output reg debug_mode_bit_o,
  output reg [7:0] ctl_reg_o,
  output reg [15:0] counter_o,
  output reg read_req_o,
  output reg [7:0] read_cmd_o,
  output reg pc_wr_o,
  output reg [15:0] pc_wr_data_o,
  output reg reg_wr_o,
  output reg [11:0] reg_wr_addr_o,
  output reg [7:0] reg_wr_data_o,
  output reg cmd_reject_o,
  output reg frame_err_o,
  output reg baud_locked_o
);
  localparam S_CMD = 1'b0;
  localparam S_OPND = 1'b1;

  wire rx_valid;
  wire [7:0] rx_data;
  wire rx_ferr;
  wire rx_locked;
  wire dec_known;
  wire dec_allowed;
  wire [1:0] dec_opnd;

  reg state_r;
  reg [7:0] cmd_r;
  reg allowed_r;
  reg [1:0] need_r;
  reg [1:0] got_r;
  reg [23:0] opnd_r;

  // Receiver measures the leading 80H before any command
  dcg_serial_rx #(
    .CNT_W(CNT_W)
  ) u_rx (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .line_i(debug_serial_pin_i),
    .byte_valid_r(rx_valid),
    .byte_data_r(rx_data),
    .frame_err_r(rx_ferr),
    .baud_locked_r(rx_locked)
  );

  dcg_cmd_decode u_dec (
    .cmd_i(rx_data),
    .debug_mode_i(ctl_reg_o[`DCG_CTL_MODE_BIT]),
    .read_protect_i(read_protect_option_i),
    .known_o(dec_known),
    .allowed_o(dec_allowed),
    .opnd_cnt_o(dec_opnd)
  );

  // Operands assembled with the newest byte in the low lane
  wire [23:0] opnd_full = {opnd_r[15:0], rx_data};
  wire last_opnd = rx_valid && (state_r == S_OPND) &&
                   (got_r + 2'd1 == need_r);

  // Register write address and data from the three operands
  wire [11:0] wr_addr = opnd_full[19:8];
  wire [7:0] wr_data = opnd_full[7:0];
  wire in_periph = (wr_addr[11:8] == `DCG_PERIPH_PAGE);
  wire is_flash = (wr_addr == FLASH_CTL_ADDR);
  wire reg_ok = ~read_protect_option_i ||
                (in_periph && (~is_flash || wr_data == MASS_ERASE_VAL));

  // Control write value with the protection hold on the debug bit
  reg [7:0] ctl_nxt;
  always @* begin
    ctl_nxt = opnd_full[7:0];
    if (read_protect_option_i && ctl_reg_o[`DCG_CTL_MODE_BIT]) begin
      ctl_nxt[`DCG_CTL_MODE_BIT] = 1'b1;
    end
  end

  // Command sequencing, execution and refusal
  always @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= S_CMD;
      cmd_r <= 8'h00;
      allowed_r <= 1'b0;
      need_r <= 2'd0;
      got_r <= 2'd0;
      opnd_r <= 24'h000000;
      ctl_reg_o <= `DCG_CTL_RESET;
      counter_o <= `DCG_CNT_RESET;
      read_req_o <= 1'b0;
      read_cmd_o <= 8'h00;
      pc_wr_o <= 1'b0;
      pc_wr_data_o <= 16'h0000;
      reg_wr_o <= 1'b0;
      reg_wr_addr_o <= 12'h000;
      reg_wr_data_o <= 8'h00;
      cmd_reject_o <= 1'b0;
    end else begin
      read_req_o <= 1'b0;
      pc_wr_o <= 1'b0;
      reg_wr_o <= 1'b0;
      cmd_reject_o <= 1'b0;
      case (state_r)
        S_CMD: begin
          if (rx_valid) begin
            // Every received byte in this state is a command
            cmd_r <= rx_data;
            got_r <= 2'd0;
            opnd_r <= 24'h000000;
            if (!dec_known) begin
              cmd_reject_o <= 1'b1;
            end else if (dec_opnd == 2'd0) begin
              // Reads carry no operands and act at once
              if (dec_allowed) begin
                read_req_o <= 1'b1;
                read_cmd_o <= rx_data;
              end else begin
                cmd_reject_o <= 1'b1;
              end
            end else begin
              // Refused writes still swallow operands to keep framing
              allowed_r <= dec_allowed;
              need_r <= dec_opnd;
              state_r <= S_OPND;
            end
          end
        end
        S_OPND: begin
          if (rx_valid) begin
            opnd_r <= opnd_full;
            got_r <= got_r + 2'd1;
          end
          if (last_opnd) begin
            state_r <= S_CMD;
            if (!allowed_r) begin
              cmd_reject_o <= 1'b1;
            end else begin
              case (cmd_r)
                `DCG_CMD_WR_CNT: begin
                  counter_o <= opnd_full[15:0];
                end
                `DCG_CMD_WR_CTL: begin
                  ctl_reg_o <= ctl_nxt;
                end
                `DCG_CMD_WR_PC: begin
                  pc_wr_o <= 1'b1;
                  pc_wr_data_o <= opnd_full[15:0];
                end
                `DCG_CMD_WR_REG: begin
                  if (reg_ok) begin
                    reg_wr_o <= 1'b1;
                    reg_wr_addr_o <= wr_addr;
                    reg_wr_data_o <= wr_data;
                  end else begin
                    cmd_reject_o <= 1'b1;
                  end
                end
                default: begin
                  cmd_reject_o <= 1'b1;
                end
              endcase
            end
          end
        end
        default: begin
          state_r <= S_CMD;
        end
      endcase
    end
  end

  // Status outputs registered; the pin is never driven by this block
  always @(posedge clk_i) begin
    if (reset_i) begin
      debug_mode_bit_o <= 1'b0;
      debug_serial_pin_o <= 1'b0;
      debug_serial_pin_oe_o <= 1'b0;
      frame_err_o <= 1'b0;
      baud_locked_o <= 1'b0;
    end else begin
      // One cycle behind the control register bit
      debug_mode_bit_o <= ctl_reg_o[`DCG_CTL_MODE_BIT];
      debug_serial_pin_o <= 1'b0;
      debug_serial_pin_oe_o <= 1'b0;
      frame_err_o <= rx_ferr;
      baud_locked_o <= rx_locked;
    end
  end

endmodule
`default_nettype wire

// [test/dcg_debug_command_gate_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module dcg_checker #(
  parameter [11:0] FLASH_CTL_ADDR = 12'hff8,
  parameter [7:0] MASS_ERASE_VAL = 8'h95
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic read_protect_option_i,
  input wire logic debug_mode_bit_o,
  input wire logic [7:0] ctl_reg_o,
  input wire logic [15:0] counter_o,
  input wire logic read_req_o,
  input wire logic [7:0] read_cmd_o,
  input wire logic pc_wr_o,
  input wire logic reg_wr_o,
  input wire logic [11:0] reg_wr_addr_o,
  input wire logic [7:0] reg_wr_data_o,
  input wire logic cmd_reject_o,
  input wire logic baud_locked_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Mode bit edges in the control register
  sequence s_set; $rose(ctl_reg_o[7]); endsequence
  sequence s_clr; $fell(ctl_reg_o[7]); endsequence
  property p_enter; s_set |=> debug_mode_bit_o; endproperty
  a_enter: assert property (p_enter) else $error("mode not entered");
  property p_exit; s_clr |=> !debug_mode_bit_o; endproperty
  a_exit: assert property (p_exit) else $error("mode not left");
  property p_one;
    $onehot0({read_req_o, cmd_reject_o, pc_wr_o, reg_wr_o});
  endproperty
  a_one: assert property (p_one) else $error("outcomes overlap");
  property p_keep;
    read_protect_option_i && ctl_reg_o[7] |=> ctl_reg_o[7];
  endproperty
  a_keep: assert property (p_keep) else $error("mode bit cleared");
  property p_norm;
    read_req_o && !debug_mode_bit_o |-> read_cmd_o inside {8'h00, 8'h02, 8'h05};
  endproperty
  a_norm: assert property (p_norm) else $error("read outside mode");
  property p_pc;
    pc_wr_o || (read_req_o && read_cmd_o == 8'h07)
      |-> debug_mode_bit_o && !read_protect_option_i;
  endproperty
  a_pc: assert property (p_pc) else $error("pc access refused case");
  property p_page;
    reg_wr_o |-> debug_mode_bit_o
      && (!read_protect_option_i || reg_wr_addr_o[11:8] == 4'hf);
  endproperty
  a_page: assert property (p_page) else $error("register write refused");
  property p_flash;
    reg_wr_o && read_protect_option_i && reg_wr_addr_o == FLASH_CTL_ADDR
      |-> reg_wr_data_o == MASS_ERASE_VAL;
  endproperty
  a_flash: assert property (p_flash) else $error("flash write value");
  property p_cnt;
    !$stable(counter_o) && !$past(reset_i) |-> debug_mode_bit_o;
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter outside mode");
  property p_rst;
    $fell(reset_i) |-> ctl_reg_o == 8'h00 && counter_o == 16'h0000
      && !debug_mode_bit_o && !baud_locked_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind dcg_debug_command_gate dcg_checker #(
  .FLASH_CTL_ADDR(FLASH_CTL_ADDR), .MASS_ERASE_VAL(MASS_ERASE_VAL)
) dcg_checker_inst (.clk_i(clk_i), .reset_i(reset_i),
  .read_protect_option_i(read_protect_option_i),
  .debug_mode_bit_o(debug_mode_bit_o), .ctl_reg_o(ctl_reg_o),
  .counter_o(counter_o), .read_req_o(read_req_o), .read_cmd_o(read_cmd_o),
  .pc_wr_o(pc_wr_o), .reg_wr_o(reg_wr_o), .reg_wr_addr_o(reg_wr_addr_o),
  .reg_wr_data_o(reg_wr_data_o), .cmd_reject_o(cmd_reject_o),
  .baud_locked_o(baud_locked_o));
`default_nettype wire

// [test/dcg_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dcg_host_model #(
  parameter int BIT_CYC = 8
) (
  input wire logic clk_i,
  output logic line_o
);
  // Idle high; the line only moves inside characters
  initial line_o = 1'b1;
  // Start, eight bits lowest first, stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      #1 line_o = f[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// [test/debug_command_gate_test.sv]
`timescale 1ns/1ps
`default_nettype none
module debug_command_gate_test;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic rp = 1'b0;
  wire logic line, dbm, rd, rej, pcw, rgw, lock;
  wire logic pin_o, pin_oe, ferr;
  wire logic [7:0] ctl, rcmd, rgd;
  wire logic [15:0] cnt, pcd;
  wire logic [11:0] rga;
  integer error_cnt = 0;
  integer n_tests = 0;
  integer seed = 32'h6ade;
  logic [31:0] exp_q[$];
  logic [7:0] ectl = 8'h00;
  logic [15:0] ecnt = 16'h0000;
  wire logic [31:0] obs = rd ? {4'h1, 20'h0, rcmd} : rej ? 32'h2000_0000 :
    pcw ? {4'h3, 12'h0, pcd} : {4'h4, 8'h0, rga, rgd};
  always #2 clk_i = ~clk_i;
  dcg_host_model dcg_host_model_inst (.clk_i(clk_i), .line_o(line));
  dcg_debug_command_gate dcg_debug_command_gate_inst (
    .clk_i(clk_i), .reset_i(reset_i), .debug_serial_pin_i(line),
    .debug_serial_pin_o(pin_o), .debug_serial_pin_oe_o(pin_oe),
    .read_protect_option_i(rp), .debug_mode_bit_o(dbm), .ctl_reg_o(ctl),
    .counter_o(cnt), .read_req_o(rd), .read_cmd_o(rcmd), .pc_wr_o(pcw),
    .pc_wr_data_o(pcd), .reg_wr_o(rgw), .reg_wr_addr_o(rga),
    .reg_wr_data_o(rgd), .cmd_reject_o(rej), .frame_err_o(ferr),
    .baud_locked_o(lock));
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Note the outcome, then send command and operands
  task automatic issue(input logic [7:0] c, input logic [23:0] op);
    int n;
    logic ok;
    logic d;
    op[23:20] = 4'h0;
    d = ectl[7];
    n = (c == 1 || c == 6) ? 2 : (c == 4) ? 1 : (c == 8) ? 3 : 0;
    case (c)
      8'h00, 8'h02, 8'h04, 8'h05: ok = 1'b1;
      8'h01, 8'h03: ok = d;
      8'h06, 8'h07: ok = d & ~rp;
      8'h08: ok = d & (~rp | (op[19:16] == 4'hf &
        (op[19:8] != 12'hff8 | op[7:0] == 8'h95)));
      default: ok = 1'b0;
    endcase
    if (!ok) exp_q.push_back(32'h2000_0000);
    else if (c == 1) ecnt = op[15:0];
    else if (c == 4) ectl = (rp & d) ? op[7:0] | 8'h80 : op[7:0];
    else if (c == 6) exp_q.push_back({4'h3, 12'h0, op[15:0]});
    else if (c == 8) exp_q.push_back({4'h4, 8'h0, op[19:0]});
    else exp_q.push_back({4'h1, 20'h0, c});
    dcg_host_model_inst.send(c);
    for (int i = n - 1; i >= 0; i--) dcg_host_model_inst.send(op[8*i +: 8]);
    repeat (8) @(posedge clk_i);
    #1;
    chk("ctl", ctl, ectl);
    chk("counter", cnt, ecnt);
    chk("mode", dbm, ectl[7]);
    chk("pin oe", {pin_oe, pin_o}, 0);
  endtask
  // Pulses are matched against the oldest note
  always @(posedge clk_i) begin
    if (!reset_i && ferr !== 1'b0) chk("frame err", ferr, 0);
    if (rd | rej | pcw | rgw) begin
      if (exp_q.size() == 0) chk("unexpected", obs, 32'hffff_ffff);
      else chk("event", obs, exp_q.pop_front());
    end
  end
  // Normal, debug, then protected passes over every code
  initial begin
    logic [23:0] r;
    repeat (6) @(posedge clk_i);
    #1 reset_i = 1'b0;
    dcg_host_model_inst.send(8'h80);
    repeat (8) @(posedge clk_i);
    chk("locked", lock, 1'b1);
    for (int p = 0; p < 3; p++) begin
      for (int c = 0; c < 10; c++) begin
        r = 24'($random(seed));
        if (c == 4) r[7] = (p != 0);
        issue(c[7:0], r);
      end
      if (p == 0) issue(8'h04, 24'h000080);
      rp = (p >= 1);
    end
    issue(8'h04, 24'h000000);
    issue(8'h08, 24'h0f1234);
    issue(8'h08, 24'h0eff34);
    issue(8'h08, 24'h0ff895);
    issue(8'h08, 24'h0ff811);
    rp = 1'b0;
    issue(8'h04, 24'h000000);
    issue(8'h03, 24'h000000);
    issue(8'h04, 24'h000081);
    issue(8'h01, 24'h00a5c3);
    reset_i = 1'b1;
    repeat (6) @(posedge clk_i);
    #1 reset_i = 1'b0;
    chk("reset ctl", ctl, 8'h00);
    chk("reset counter", cnt, 16'h0000);
    ectl = 8'h00;
    ecnt = 16'h0000;
    dcg_host_model_inst.send(8'h80);
    issue(8'h01, 24'h00beef);
    chk("pending", exp_q.size(), 0);
    summarize;
  end
  // Cut a hang short well past the expected run
  initial begin
    #160000;
    error_cnt++;
    summarize;
  end
endmodule
`default_nettype wire
